// >>> logic/csp_pkg.sv
// Package: constants and types of the clock source, start-up and prescaler block
package csp_pkg;
  // Source-select fuse codes
  localparam logic [3:0] SRC_EXT = 4'h0;
  localparam logic [3:0] SRC_RC  = 4'h2;
  localparam logic [3:0] SRC_WD  = 4'h4;
  localparam logic [3:0] SRC_LFX = 4'h6;
  // One-hot oscillator enable positions
  localparam int OSC_EXT = 0;
  localparam int OSC_RC  = 1;
  localparam int OSC_WD  = 2;
  localparam int OSC_LFX = 3;
  // Start-up delay fuse codes
  localparam logic [1:0] SUT_FAST = 2'h0;
  localparam logic [1:0] SUT_MID  = 2'h1;
  localparam logic [1:0] SUT_SLOW = 2'h2;
  // Reset time-outs, timed by the watchdog oscillator
  localparam int WDT_HZ        = 128_000;
  localparam int T_SHORT_MS    = 4;
  localparam int T_LONG_MS     = 64;
  localparam int WDT_SHORT_CYC = T_SHORT_MS * WDT_HZ / 1000;
  localparam int WDT_LONG_CYC  = T_LONG_MS * WDT_HZ / 1000;
  // Source clock counts
  localparam int RST_CK_CYC    = 14;
  localparam int WAKE_FAST_CYC = 6;
  localparam int WAKE_1K_CYC   = 1024;
  localparam int WAKE_32K_CYC  = 32768;
  localparam int UNLOCK_CYC    = 4;
  // Prescaler select
  localparam logic [3:0] DIV_RST_BY8 = 4'h3;
  localparam logic [3:0] DIV_RST_BY1 = 4'h0;
  localparam logic [3:0] DIV_MAX_SEL = 4'h8;
  localparam int         UNLOCK_BIT  = 7;
  localparam logic [7:0] TRIM_RST    = 8'h00;
  // Register offsets
  localparam logic [3:0] ADDR_CLKDIV = 4'h0;
  localparam logic [3:0] ADDR_TRIM   = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [3:0] src_sel;
    logic [1:0] startup_delay_fuses;
    logic       div8_fuse;
  } csp_fuse_t;

  typedef struct packed {
    logic core;
    logic periph;
    logic conv;
    logic flash;
  } csp_dom_en_t;
endpackage

// >>> logic/csp_divider.sv
// Prescaler counter: one tick per divided period, factor changed on a boundary
`timescale 1ns/1ps
module csp_divider
  import csp_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       rst_b_in,
  input  wire logic [3:0] sel_in,
  output logic            tick_out
);
  logic [7:0] cnt_reg;
  logic [3:0] act_sel_reg;
  logic [7:0] limit;
  logic [3:0] sel_c;
  logic       at_end;

  assign limit  = 8'((9'h001 << act_sel_reg) - 9'h001);
  assign sel_c  = (sel_in > DIV_MAX_SEL) ? DIV_MAX_SEL : sel_in;
  assign at_end = (cnt_reg == limit);

  // Counter runs on the undivided clock and is never visible to software
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt_reg <= 8'h00;
    end else if (at_end) begin
      cnt_reg <= 8'h00;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end

  // New factor only at the end of an old period, so the first new period is whole
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      act_sel_reg <= DIV_RST_BY1;
    end else if (at_end) begin
      act_sel_reg <= sel_c;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tick_out <= 1'b0;
    end else begin
      tick_out <= at_end;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  a_switch_boundary: assert property ($changed(act_sel_reg) |-> $past(at_end))
    else $error("prescaler factor changed inside a period");
  a_tick_by_four: assert property (at_end && act_sel_reg == 4'h2 && sel_c == 4'h2
      |=> !at_end [*3] ##1 at_end)
    else $error("divide by four period wrong");
endmodule

// >>> logic/csp_startup.sv
// Start-up sequencer: reset delay after release and wake-up delay after sleep
`timescale 1ns/1ps
module csp_startup
  import csp_pkg::*;
#(
  parameter int WAKE_LONG = WAKE_32K_CYC,
  parameter int RST_LONG  = WDT_LONG_CYC
) (
  input  wire logic      clk_in,
  input  wire logic      rst_b_in,
  input  wire csp_fuse_t fuses_in,
  input  wire logic      sleep_in,
  input  wire logic      wdt_tick_in,
  output logic           run_out
);
  typedef enum logic [2:0] {ST_INIT, ST_CK, ST_WDT, ST_RUN, ST_SLEEP, ST_WAKE} csp_st_t;
  csp_st_t    st_reg;
  csp_fuse_t  fuse_reg;
  logic [15:0] cnt_reg;
  logic [15:0] wdt_n;
  logic [15:0] wake_n;
  logic        is_lfx;

  assign is_lfx = (fuses_in.src_sel == SRC_LFX);

  // Watchdog cycles of the reset time-out, minus one; zero means none
  always_comb begin
    wdt_n = 16'h0000;
    unique case (fuses_in.startup_delay_fuses)
      SUT_FAST: wdt_n = is_lfx ? 16'(WDT_SHORT_CYC - 1) : 16'h0000;
      SUT_MID:  wdt_n = is_lfx ? 16'(RST_LONG - 1) : 16'(WDT_SHORT_CYC - 1);
      default:  wdt_n = 16'(RST_LONG - 1);
    endcase
  end

  always_comb begin
    if (fuse_reg.src_sel != SRC_LFX) begin
      wake_n = 16'(WAKE_FAST_CYC - 1);
    end else if (fuse_reg.startup_delay_fuses == SUT_SLOW) begin
      wake_n = 16'(WAKE_LONG - 1);
    end else begin
      wake_n = 16'(WAKE_1K_CYC - 1);
    end
  end

  // Watchdog ticks time the real-time part even when another source runs the core
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_reg   <= ST_INIT;
      cnt_reg  <= 16'h0000;
      run_out  <= 1'b0;
      fuse_reg <= '0;
    end else begin
      unique case (st_reg)
        ST_INIT: begin
          fuse_reg <= fuses_in;
          if (is_lfx) begin
            st_reg  <= ST_WDT;
            cnt_reg <= wdt_n;
          end else begin
            st_reg  <= ST_CK;
            cnt_reg <= 16'(RST_CK_CYC - 1);
          end
        end
        ST_CK: begin
          if (cnt_reg != 16'h0000) begin
            cnt_reg <= cnt_reg - 16'h0001;
          end else if (wdt_n == 16'h0000 && fuse_reg.startup_delay_fuses == SUT_FAST) begin
            st_reg  <= ST_RUN;
            run_out <= 1'b1;
          end else begin
            st_reg  <= ST_WDT;
            cnt_reg <= wdt_n;
          end
        end
        ST_WDT: begin
          if (wdt_tick_in && cnt_reg == 16'h0000) begin
            st_reg  <= ST_RUN;
            run_out <= 1'b1;
          end else if (wdt_tick_in) begin
            cnt_reg <= cnt_reg - 16'h0001;
          end
        end
        ST_RUN: begin
          if (sleep_in) begin
            st_reg  <= ST_SLEEP;
            run_out <= 1'b0;
          end
        end
        ST_SLEEP: begin
          if (!sleep_in) begin
            st_reg  <= ST_WAKE;
            cnt_reg <= wake_n;
          end
        end
        ST_WAKE: begin
          if (cnt_reg != 16'h0000) begin
            cnt_reg <= cnt_reg - 16'h0001;
          end else begin
            st_reg  <= ST_RUN;
            run_out <= 1'b1;
          end
        end
      endcase
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  sequence s_wake_start;
    st_reg == ST_SLEEP && !sleep_in && fuse_reg.src_sel != SRC_LFX;
  endsequence
  // Six counted cycles in wake, plus the cycle that leaves sleep
  a_wake_six: assert property (s_wake_start |-> !run_out [*7] ##1 run_out)
    else $error("fast wake-up not six cycles");
  // Sampled reset keeps the release edge itself from starting an attempt
  a_rc_reset_fast: assert property (rst_b_in && st_reg == ST_INIT
      && fuses_in.src_sel == SRC_RC && fuses_in.startup_delay_fuses == SUT_FAST
      |-> !run_out [*8] ##8 run_out)
    else $error("reset delay of fourteen cycles wrong");
endmodule

// >>> logic/csp_top.sv
// Clock source select, start-up timing and system clock prescaler with AXI4-Lite registers
// What this block does
// - Fuses 0110 select low-frequency crystal
// - Crystal start-up and reset delays per fuses
// - Fuses 0010 select 8 MHz RC oscillator
// - Factory trim loads into trim register
// - RC wake 6 cycles, reset delays per fuses
// - Watchdog oscillator times reset time-out
// - Fuses 0000 select external clock input
// - External clock wake 6, reset delays per fuses
// - Fuses 0100 select 128 kHz oscillator
// - 128 kHz wake 6, reset delays per fuses
// - All four domains divided by same factor
// - Divider switch without glitch or overspeed
// - Ripple counter on undivided clock, not readable
// - New factor active after old plus new period
// - Unlock bit gates divider writes, four-cycle timeout
// - Select codes 0 to 8 divide 1..256
// - Reset select from divide-by-eight fuse
//
// Design decisions made here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
module csp_top
  import csp_pkg::*;
#(
  parameter int WAKE_LONG = WAKE_32K_CYC,
  parameter int RST_LONG  = WDT_LONG_CYC
) (
  input  wire logic        mclk_in,
  input  wire logic        rst_b_in,
  input  wire csp_fuse_t   fuses_in,
  input  wire logic [7:0]  factory_trim_in,
  input  wire logic        sleep_in,
  input  wire logic        wdt_tick_in,
  input  wire logic [3:0]  s_axi_awaddr_in,
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  output logic [1:0]       s_axi_bresp_out,
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  input  wire logic [3:0]  s_axi_araddr_in,
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  output logic [3:0]       osc_en_out,
  output csp_dom_en_t      dom_en_out,
  output logic [7:0]       trim_out,
  output logic             core_run_out
);
  logic       init_reg;
  logic [3:0] div_sel_reg;
  logic       unlock_reg;
  logic [1:0] unlock_cnt_reg;
  logic       aw_hold_reg;
  logic       w_hold_reg;
  logic [3:0] awaddr_reg;
  logic [7:0] wdata_reg;
  logic       wlane_reg;
  logic       wr_fire;
  logic       wr_div;
  logic       rd_fire;
  logic       div_tick;
  logic       run;
  logic [31:0] rd_mux;

  //////////////////////////////////////////////////////////////////////////////
  // Register bus

  assign wr_fire = aw_hold_reg && w_hold_reg && !s_axi_bvalid_out;
  assign wr_div  = wr_fire && wlane_reg && awaddr_reg[3:2] == ADDR_CLKDIV[3:2];
  assign rd_fire = s_axi_arvalid_in && s_axi_arready_out;

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      aw_hold_reg       <= 1'b0;
      w_hold_reg        <= 1'b0;
      awaddr_reg        <= 4'h0;
      wdata_reg         <= 8'h00;
      wlane_reg         <= 1'b0;
      s_axi_awready_out <= 1'b1;
      s_axi_wready_out  <= 1'b1;
      s_axi_bvalid_out  <= 1'b0;
      s_axi_bresp_out   <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_hold_reg       <= 1'b1;
        awaddr_reg        <= s_axi_awaddr_in;
        s_axi_awready_out <= 1'b0;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_hold_reg       <= 1'b1;
        wdata_reg        <= s_axi_wdata_in[7:0];
        wlane_reg        <= s_axi_wstrb_in[0];
        s_axi_wready_out <= 1'b0;
      end
      if (wr_fire) begin
        aw_hold_reg      <= 1'b0;
        w_hold_reg       <= 1'b0;
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out  <= (awaddr_reg[3:2] == 2'h3) ? RESP_SLVERR : RESP_OKAY;
      end
      if (s_axi_bvalid_out && s_axi_bready_in) begin
        s_axi_bvalid_out  <= 1'b0;
        s_axi_awready_out <= 1'b1;
        s_axi_wready_out  <= 1'b1;
      end
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (s_axi_araddr_in[3:2])
      ADDR_CLKDIV[3:2]: rd_mux = {24'h00_0000, unlock_reg, 3'h0, div_sel_reg};
      ADDR_TRIM[3:2]:   rd_mux = {24'h00_0000, trim_out};
      ADDR_STATUS[3:2]: rd_mux = {24'h00_0000, osc_en_out, 2'h0, init_reg, core_run_out};
      default:          rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out  <= 1'b0;
      s_axi_rdata_out   <= 32'h0000_0000;
      s_axi_rresp_out   <= RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out  <= 1'b1;
      s_axi_rdata_out   <= rd_mux;
      s_axi_rresp_out   <= (s_axi_araddr_in[3:2] == 2'h3) ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_rvalid_out && s_axi_rready_in) begin
      s_axi_rvalid_out  <= 1'b0;
      s_axi_arready_out <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Calibration and prescaler registers

  // Fuse and factory values are caught on the first edge after release,
  // since an asynchronous reset may only load constants
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      init_reg <= 1'b0;
      trim_out <= TRIM_RST;
    end else if (!init_reg) begin
      init_reg <= 1'b1;
      trim_out <= factory_trim_in;
    end else if (wr_fire && wlane_reg && awaddr_reg[3:2] == ADDR_TRIM[3:2]) begin
      trim_out <= wdata_reg;
    end
  end

  // Unlock only on a write of the bit alone; a repeat neither extends nor clears it
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      unlock_reg     <= 1'b0;
      unlock_cnt_reg <= 2'h0;
    end else if (wr_div && !wdata_reg[UNLOCK_BIT] && unlock_reg) begin
      unlock_reg <= 1'b0;
    end else if (wr_div && wdata_reg == 8'h80 && !unlock_reg) begin
      unlock_reg     <= 1'b1;
      unlock_cnt_reg <= 2'(UNLOCK_CYC - 1);
    end else if (unlock_reg && unlock_cnt_reg == 2'h0) begin
      unlock_reg <= 1'b0;
    end else if (unlock_reg) begin
      unlock_cnt_reg <= unlock_cnt_reg - 2'h1;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      div_sel_reg <= DIV_RST_BY1;
    end else if (!init_reg) begin
      div_sel_reg <= fuses_in.div8_fuse ? DIV_RST_BY1 : DIV_RST_BY8;
    end else if (wr_div && !wdata_reg[UNLOCK_BIT] && unlock_reg) begin
      div_sel_reg <= wdata_reg[3:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Source select, start-up and clock domains

  // Reserved codes enable no oscillator at all
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      osc_en_out <= 4'h0;
    end else begin
      osc_en_out[OSC_EXT] <= fuses_in.src_sel == SRC_EXT;
      osc_en_out[OSC_RC]  <= fuses_in.src_sel == SRC_RC;
      osc_en_out[OSC_WD]  <= fuses_in.src_sel == SRC_WD;
      osc_en_out[OSC_LFX] <= fuses_in.src_sel == SRC_LFX;
    end
  end

  csp_startup #(
    .WAKE_LONG (WAKE_LONG),
    .RST_LONG  (RST_LONG)
  ) u_startup (
    .clk_in      (mclk_in),
    .rst_b_in    (rst_b_in),
    .fuses_in    (fuses_in),
    .sleep_in    (sleep_in),
    .wdt_tick_in (wdt_tick_in),
    .run_out     (run)
  );

  csp_divider u_divider (
    .clk_in   (mclk_in),
    .rst_b_in (rst_b_in),
    .sel_in   (div_sel_reg),
    .tick_out (div_tick)
  );

  // Enables rather than gated clocks: one clock tree, no runt pulses
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      dom_en_out   <= '0;
      core_run_out <= 1'b0;
    end else begin
      core_run_out <= run;
      dom_en_out   <= {4{run && div_tick}};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);

  a_unlock_timeout: assert property ($rose(unlock_reg) |-> ##[1:4] !unlock_reg)
    else $error("unlock bit outlived its window");
  a_unlock_gate: assert property (init_reg && $past(init_reg) && $changed(div_sel_reg)
      |-> $past(unlock_reg))
    else $error("divider select changed while locked");
  a_div_reset: assert property ($rose(init_reg)
      |-> div_sel_reg == ($past(fuses_in.div8_fuse) ? DIV_RST_BY1 : DIV_RST_BY8))
    else $error("divider select reset value wrong");
  a_trim_load: assert property ($rose(init_reg) |-> trim_out == $past(factory_trim_in))
    else $error("factory trim not loaded");
  // Sampled reset keeps the release edge, where enables still read zero, out
  a_src_lfx: assert property (rst_b_in && fuses_in.src_sel == SRC_LFX
      |=> osc_en_out == 4'h8)
    else $error("crystal source not selected");
  a_src_rc: assert property (rst_b_in && fuses_in.src_sel == SRC_RC
      |=> osc_en_out == 4'h2)
    else $error("RC source not selected");
  a_src_ext: assert property (rst_b_in && fuses_in.src_sel == SRC_EXT
      |=> osc_en_out == 4'h1)
    else $error("external source not selected");
  a_src_wd: assert property (rst_b_in && fuses_in.src_sel == SRC_WD
      |=> osc_en_out == 4'h4)
    else $error("128 kHz source not selected");
  a_dom_equal: assert property (dom_en_out.core == dom_en_out.periph
      && dom_en_out.conv == dom_en_out.flash && dom_en_out.core == dom_en_out.conv)
    else $error("clock domains divided differently");
  // Both registered from the same run flag, so the domain enables are low whenever core_run_out is low
  a_dom_halt: assert property (!core_run_out |-> dom_en_out == '0)
    else $error("domain clock active before run");
  a_bresp: assert property (wr_fire |=> s_axi_bvalid_out)
    else $error("write response missing");

  // Divider changes in two steps: open the window, then write the select
  sequence s_unlock_open;
    wr_div && wdata_reg == 8'h80 && !unlock_reg;
  endsequence
  sequence s_select_write;
    wr_div && !wdata_reg[UNLOCK_BIT] && unlock_reg;
  endsequence
  a_unlock_set: assert property (s_unlock_open |=> unlock_reg)
    else $error("unlock bit not set");
  a_select_update: assert property (s_select_write
      |=> !unlock_reg && div_sel_reg == $past(wdata_reg[3:0]))
    else $error("divider select not taken");
  a_locked_hold: assert property (init_reg && wr_div && !unlock_reg
      |=> $stable(div_sel_reg))
    else $error("divider select moved while locked");
  a_trim_write: assert property (init_reg && wr_fire && wlane_reg
      && awaddr_reg[3:2] == ADDR_TRIM[3:2] |=> trim_out == $past(wdata_reg))
    else $error("trim write lost");
  a_init_once: assert property (init_reg |=> init_reg)
    else $error("factory load repeated");

  // Bus answers one cycle after the take and blocks new requests meanwhile
  a_write_block: assert property (s_axi_bvalid_out
      |-> !s_axi_awready_out && !s_axi_wready_out)
    else $error("new write accepted before response");
  a_read_answer: assert property (rd_fire |=> s_axi_rvalid_out && !s_axi_arready_out)
    else $error("read answer missing");
  a_read_slverr: assert property (rd_fire && s_axi_araddr_in[3:2] == 2'h3
      |=> s_axi_rresp_out == RESP_SLVERR && s_axi_rdata_out == 32'h0000_0000)
    else $error("unmapped read not refused");

  // Core and domain enables follow the start-up sequencer
  a_sleep_stop: assert property (sleep_in && core_run_out |-> ##2 !core_run_out)
    else $error("core kept running in sleep");
  a_dom_run: assert property (dom_en_out.core |-> core_run_out)
    else $error("domain enable without run");
  a_osc_onehot: assert property ($onehot0(osc_en_out))
    else $error("more than one oscillator enabled");
endmodule

// >>> tb/csp_osc_model.sv
// Partner model: watchdog oscillator tick source and factory calibration byte
`timescale 1ns/1ps
module csp_osc_model #(
  parameter int         TICK_DIV = 4,
  parameter logic [7:0] TRIM_VAL = 8'ha5
) (
  input  wire logic       clk_in,
  input  wire logic       rst_b_in,
  output logic            wdt_tick_out,
  output logic [7:0]      trim_out
);
  int cnt;

  // Calibration byte is fixed silicon content, always presented
  assign trim_out = TRIM_VAL;

  ////////////////////////////////////////////////////////////////////////////
  // Ticks run whatever source is chosen; divided down to keep runs short
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt          <= 0;
      wdt_tick_out <= 1'b0;
    end else begin
      cnt          <= (cnt == TICK_DIV - 1) ? 0 : cnt + 1;
      wdt_tick_out <= (cnt == TICK_DIV - 1);
    end
  end
endmodule

// >>> tb/csp_top_tb.sv
// Testbench of the clock source, start-up and prescaler block
`timescale 1ns/1ps
module csp_top_tb;
  import csp_pkg::*;
  localparam int         DIV   = 4;
  localparam logic [7:0] FTRIM = 8'ha5;
  localparam int         LIMIT = 40000;

  `define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin fails++; \
    $display("ERROR t=%0t got %0h exp %0h", $time, got, exp); end end

  logic mclk_in = 1'b0, rst_b = 1'b0, sleep = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
  logic bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, rv;
  logic [1:0] bresp, rresp, last_resp;
  logic awready, wready, bvalid, arready, rvalid, core_run, wdt_tick;
  logic [3:0] osc_en;
  logic [7:0] trim, ftrim;
  csp_dom_en_t dom_en;
  csp_fuse_t fuses = '0;
  int fails = 0, n_compared = 0, cycles = 0, n, lo, p;

  logic [3:0] c_src [6] = '{SRC_RC, SRC_RC, SRC_EXT, SRC_WD, SRC_LFX, SRC_LFX};
  logic [1:0] c_dly [6] = '{2'h0, 2'h1, 2'h2, 2'h0, 2'h0, 2'h2};
  logic       c_d8  [6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
  int         c_tk  [6] = '{0, 512, 16, 0, 512, 16};
  int         c_ck  [6] = '{14, 14, 14, 14, 0, 0};
  int         c_wk  [6] = '{6, 6, 6, 6, 1024, 64};
  logic [3:0] c_osc [6] = '{4'h2, 4'h2, 4'h1, 4'h4, 4'h8, 4'h8};

  // Steady source clock: no cycle-to-cycle frequency change at all
  always #20 mclk_in = ~mclk_in;

  csp_top #(.WAKE_LONG(64), .RST_LONG(16)) uut (
    .mclk_in(mclk_in), .rst_b_in(rst_b), .fuses_in(fuses), .factory_trim_in(ftrim),
    .sleep_in(sleep), .wdt_tick_in(wdt_tick),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .osc_en_out(osc_en),
    .dom_en_out(dom_en), .trim_out(trim), .core_run_out(core_run));

  csp_osc_model #(.TICK_DIV(DIV), .TRIM_VAL(FTRIM)) osc (
    .clk_in(mclk_in), .rst_b_in(rst_b), .wdt_tick_out(wdt_tick), .trim_out(ftrim));

  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == LIMIT) begin
      fails++;
      $display("ERROR t=%0t timeout", $time);
      summarize();
    end
  end

  // Every domain must see the same enable in every cycle
  always @(posedge mclk_in) begin
    if (rst_b) begin
      `CHK({dom_en.periph, dom_en.conv, dom_en.flash}, {3{dom_en.core}})
    end
  end

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge mclk_in);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge mclk_in);
      if (!aw_ok && awready) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge mclk_in); while (bvalid !== 1'b1);
    last_resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge mclk_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge mclk_in); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge mclk_in); while (rvalid !== 1'b1);
    d = rdata;
    last_resp = rresp;
    rready <= 1'b0;
  endtask

  // Gap between two enable pulses of the core domain, in source cycles
  task automatic period(output int q);
    int t;
    t = 0;
    do @(posedge mclk_in); while (dom_en.core !== 1'b1 && t++ < 600);
    q = 0;
    do begin
      @(posedge mclk_in);
      q++;
    end while (dom_en.core !== 1'b1 && q < 600);
  endtask

  task automatic wait_run(output int m);
    m = 0;
    while (core_run !== 1'b1 && m < 5000) begin
      @(posedge mclk_in);
      m++;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    for (int i = 0; i < 6; i++) begin
      @(posedge mclk_in);
      rst_b <= 1'b0;
      fuses <= {c_src[i], c_dly[i], c_d8[i]};
      repeat (20) @(posedge mclk_in);
      rst_b <= 1'b1;
      wait_run(n);
      lo = c_ck[i] + c_tk[i] * DIV;
      `CHK(n >= lo && n <= lo + DIV + 6, 1'b1)
      `CHK(osc_en, c_osc[i])
      `CHK(trim, FTRIM)
      rd(ADDR_CLKDIV, rv);
      `CHK(rv[7:0], c_d8[i] ? DIV_RST_BY1 : DIV_RST_BY8)
      @(posedge mclk_in);
      sleep <= 1'b1;
      repeat (4) @(posedge mclk_in);
      `CHK(core_run, 1'b0)
      sleep <= 1'b0;
      wait_run(n);
      `CHK(n >= c_wk[i] && n <= c_wk[i] + 4, 1'b1)
    end
    // Trim register is software writable after the factory load
    wr(ADDR_TRIM, 32'h0000005a);
    `CHK(last_resp, RESP_OKAY)
    rd(ADDR_TRIM, rv);
    `CHK(rv, 32'h0000005a)
    `CHK(trim, 8'h5a)
    rd(4'hc, rv);
    `CHK(last_resp, RESP_SLVERR)
    rd(ADDR_STATUS, rv);
    `CHK(rv, 32'h00000083)
    // Every select code, each behind its own unlock
    for (int k = 0; k <= 8; k++) begin
      wr(ADDR_CLKDIV, 32'h00000080);
      wr(ADDR_CLKDIV, 32'(k));
      rd(ADDR_CLKDIV, rv);
      `CHK(rv, 32'(k))
      period(p);
      period(p);
      period(p);
      `CHK(p, 1 << k)
    end
    // Locked writes and a stale unlock leave the select alone
    wr(ADDR_CLKDIV, 32'h00000001);
    wr(ADDR_CLKDIV, 32'h00000081);
    rd(ADDR_CLKDIV, rv);
    `CHK(rv, 32'h00000008)
    wr(ADDR_CLKDIV, 32'h00000080);
    repeat (6) @(posedge mclk_in);
    wr(ADDR_CLKDIV, 32'h00000001);
    rd(ADDR_CLKDIV, rv);
    `CHK(rv, 32'h00000008)
    period(p);
    `CHK(p, 256)
    summarize();
  end
endmodule
